// file: rtl/tape_unit_offline_stimulus.sv
// Stimulus and control logic of the off-line tape tester.
// Assumes panel switches and drive signals are synchronous to mclk;
// software sets the stop phase length over a plain register port.
`timescale 1ns/1ps
`include "tester_defs.svh"

module tape_unit_offline_stimulus #(
	parameter int unsigned RUN_CYC = `RUN_CYC,
	parameter int unsigned STOP_MIN_CYC = `STOP_MIN_CYC,
	parameter int unsigned STOP_MAX_CYC = `STOP_MAX_CYC,
	parameter int unsigned HI_PERIOD_CYC = `HI_PERIOD_CYC,
	parameter int unsigned LO_PERIOD_CYC = `LO_PERIOD_CYC,
	parameter int unsigned WPULSE_CYC = `WPULSE_CYC,
	parameter int unsigned TRACKS = `TRACK_COUNT
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire tester_pkg::motion_mode_e motion_mode,
	input wire logic write_enable,
	input wire logic write_rate_select,
	input wire logic read_write_sel,
	input wire logic direction_sel,
	input wire logic tape_indicate_sel,
	input wire logic load_rewind_req,
	input wire logic rewind_unload_req,
	input wire logic drive_ready,
	input wire logic [TRACKS-1:0] track_setting,
	input wire logic [TRACKS:0] read_bus,
	input wire logic [2:0] read_scan_sel,
	output logic tape_motion,
	output logic motion_sync,
	output logic write_pulse,
	output logic [TRACKS-1:0] track_data,
	output tester_pkg::drive_cmd_s drive_cmd,
	output logic skew_sync,
	output logic read_monitor
);

	////////////////////////////////////////////////////////////////////////
	// Register port

	logic [31:0] stop_time_r;
	logic [31:0] stop_len;
	tester_pkg::mv_state_e mv_state_r;
	logic [31:0] mv_count_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stop_time_r <= `STOP_MIN_CYC;
		end else if (reg_write && reg_addr == `REG_STOP_TIME) begin
			stop_time_r <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_read) begin
			case (reg_addr)
				`REG_STOP_TIME: reg_rdata <= stop_time_r;
				`REG_STATUS: reg_rdata <= {28'h0000000, write_pulse,
					motion_sync, tape_motion, mv_state_r == tester_pkg::MV_RUN};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Stop phase clamped to its adjustable range
	always_comb begin
		if (stop_time_r < STOP_MIN_CYC) begin
			stop_len = STOP_MIN_CYC; // RULE4
		end else if (stop_time_r > STOP_MAX_CYC) begin
			stop_len = STOP_MAX_CYC; // RULE4
		end else begin
			stop_len = stop_time_r;
		end
	end

	chk_stop_clamp: assert property (@(posedge mclk) // RULE4
		disable iff (!rst_n)
		stop_len >= STOP_MIN_CYC && stop_len <= STOP_MAX_CYC)
		else $error("stop length outside its range");
	chk_read_idle: assert property (@(posedge mclk)
		disable iff (!rst_n)
		!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
		else $error("read data not cleared after read");
	chk_stop_readback: assert property (@(posedge mclk)
		disable iff (!rst_n)
		$past(reg_read) && $past(reg_addr) == `REG_STOP_TIME
		|-> reg_rdata == $past(stop_time_r))
		else $error("stop time read back wrong");

	////////////////////////////////////////////////////////////////////////
	// Start-stop multivibrator

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mv_state_r <= tester_pkg::MV_RUN;
			mv_count_r <= 32'h0000_0000;
		end else begin
			case (mv_state_r)
				tester_pkg::MV_RUN: begin
					if (mv_count_r >= RUN_CYC - 1) begin
						mv_state_r <= tester_pkg::MV_STOP; // RULE20
						mv_count_r <= 32'h0000_0000;
					end else begin
						mv_count_r <= mv_count_r + 32'h1; // RULE5
					end
				end
				tester_pkg::MV_STOP: begin
					if (mv_count_r >= stop_len - 1) begin
						mv_state_r <= tester_pkg::MV_RUN; // RULE20
						mv_count_r <= 32'h0000_0000;
					end else begin
						mv_count_r <= mv_count_r + 32'h1; // RULE4
					end
				end
				default: begin
					mv_state_r <= tester_pkg::MV_RUN;
					mv_count_r <= 32'h0000_0000;
				end
			endcase
		end
	end

	sequence stop_end_s;
		mv_state_r == tester_pkg::MV_STOP && mv_count_r >= stop_len - 1;
	endsequence

	chk_stop_end: assert property (@(posedge mclk) // RULE20
		disable iff (!rst_n)
		stop_end_s |=> mv_state_r == tester_pkg::MV_RUN && mv_count_r == 0)
		else $error("stop phase did not hand over to run");
	chk_run_bound: assert property (@(posedge mclk) // RULE5
		disable iff (!rst_n)
		mv_state_r == tester_pkg::MV_RUN |-> mv_count_r < RUN_CYC)
		else $error("run phase too long");
	chk_mv_legal: assert property (@(posedge mclk) // RULE20
		disable iff (!rst_n)
		mv_state_r == tester_pkg::MV_RUN || mv_state_r == tester_pkg::MV_STOP)
		else $error("multivibrator state not one-hot");

	// Motion sync always shows the multivibrator
	assign motion_sync = (mv_state_r == tester_pkg::MV_RUN); // RULE6

	// Motion command; end of tape is not an input at all
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tape_motion <= 1'b0;
		end else begin
			case (motion_mode)
				tester_pkg::MOTION_STOP: tape_motion <= 1'b0; // RULE1
				tester_pkg::MOTION_RUN: tape_motion <= 1'b1; // RULE2 RULE19
				tester_pkg::MOTION_START_STOP:
					tape_motion <= motion_sync; // RULE3
				default: tape_motion <= 1'b0;
			endcase
		end
	end

	chk_mode_spare: assert property (@(posedge mclk) // RULE1
		disable iff (!rst_n)
		$past(motion_mode) == 2'h3 |-> !tape_motion)
		else $error("motion active with spare mode code");

	////////////////////////////////////////////////////////////////////////
	// Write pulse oscillator

	logic [31:0] osc_count_r;
	logic [31:0] osc_period_r;
	logic osc_wrap;

	assign osc_wrap = (osc_count_r >= osc_period_r - 1);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			osc_count_r <= 32'h0000_0000;
			osc_period_r <= 32'(HI_PERIOD_CYC);
		end else if (osc_wrap) begin
			osc_count_r <= 32'h0000_0000;
			osc_period_r <= write_rate_select ? HI_PERIOD_CYC
				: LO_PERIOD_CYC; // RULE7 RULE8 RULE21
		end else begin
			osc_count_r <= osc_count_r + 32'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			write_pulse <= 1'b0;
		end else begin
			write_pulse <= write_enable && (osc_count_r < WPULSE_CYC); // RULE9
		end
	end

	sequence hi_wrap_s;
		osc_wrap && write_rate_select;
	endsequence
	sequence lo_wrap_s;
		osc_wrap && !write_rate_select;
	endsequence

	chk_hi_rate: assert property (@(posedge mclk) // RULE7
		disable iff (!rst_n)
		hi_wrap_s |=> osc_period_r == HI_PERIOD_CYC)
		else $error("high density period wrong");
	chk_lo_rate: assert property (@(posedge mclk) // RULE8
		disable iff (!rst_n)
		lo_wrap_s |=> osc_period_r == LO_PERIOD_CYC)
		else $error("low density period wrong");
	chk_osc_bound: assert property (@(posedge mclk) // RULE21
		disable iff (!rst_n)
		osc_count_r < osc_period_r)
		else $error("oscillator count past its period");
	chk_wp_window: assert property (@(posedge mclk) // RULE21
		disable iff (!rst_n)
		write_pulse |-> $past(osc_count_r) < WPULSE_CYC)
		else $error("write pulse outside its window");
	chk_wp_emit: assert property (@(posedge mclk) // RULE9
		disable iff (!rst_n)
		$past(rst_n) && $past(write_enable) && $past(osc_count_r) < WPULSE_CYC
		|-> write_pulse)
		else $error("write pulse missing while enabled");

	////////////////////////////////////////////////////////////////////////
	// Drive commands and track data

	genvar gi;
	generate
		for (gi = 0; gi < TRACKS; gi++) begin : g_track
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					track_data[gi] <= 1'b0;
				end else begin
					track_data[gi] <= track_setting[gi]; // RULE10 RULE11
				end
			end
		end
	endgenerate

	chk_track_copy: assert property (@(posedge mclk) // RULE10 RULE11
		disable iff (!rst_n)
		$past(rst_n) |-> track_data == $past(track_setting))
		else $error("track data not copied from setting");

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			drive_cmd <= '0;
		end else begin
			drive_cmd.set_write <= read_write_sel; // RULE18
			drive_cmd.set_read <= !read_write_sel; // RULE18
			drive_cmd.dir_forward <= direction_sel; // RULE12
			drive_cmd.dir_backward <= !direction_sel; // RULE12
			drive_cmd.tape_indicate_on <= tape_indicate_sel; // RULE13
			drive_cmd.tape_indicate_off <= !tape_indicate_sel; // RULE13
			drive_cmd.rewind_slow <= load_rewind_req && drive_ready; // RULE14
			drive_cmd.rewind_unload <= rewind_unload_req
				&& drive_ready; // RULE15
		end
	end

	chk_rw_cmd: assert property (@(posedge mclk) // RULE18
		disable iff (!rst_n)
		$past(rst_n) |-> drive_cmd.set_write == $past(read_write_sel)
		&& drive_cmd.set_read != drive_cmd.set_write)
		else $error("read write command wrong");
	chk_dir_cmd: assert property (@(posedge mclk) // RULE12
		disable iff (!rst_n)
		$past(rst_n) |-> drive_cmd.dir_forward == $past(direction_sel)
		&& drive_cmd.dir_backward != drive_cmd.dir_forward)
		else $error("direction command wrong");
	chk_ti_cmd: assert property (@(posedge mclk) // RULE13
		disable iff (!rst_n)
		$past(rst_n) |-> drive_cmd.tape_indicate_on == $past(tape_indicate_sel)
		&& drive_cmd.tape_indicate_off != drive_cmd.tape_indicate_on)
		else $error("tape indicate command wrong");
	chk_rewind_grant: assert property (@(posedge mclk) // RULE14
		disable iff (!rst_n)
		$past(load_rewind_req && drive_ready) |-> drive_cmd.rewind_slow)
		else $error("slow rewind not issued to ready drive");
	chk_unload_grant: assert property (@(posedge mclk) // RULE15
		disable iff (!rst_n)
		$past(rewind_unload_req && drive_ready) |-> drive_cmd.rewind_unload)
		else $error("unload not issued to ready drive");

	////////////////////////////////////////////////////////////////////////
	// Monitor outputs

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			skew_sync <= 1'b0;
			read_monitor <= 1'b0;
		end else begin
			skew_sync <= read_bus[TRACKS]; // RULE16
			read_monitor <= (read_scan_sel < 3'(TRACKS))
				? read_bus[read_scan_sel] : 1'b0; // RULE17
		end
	end

	chk_read_route: assert property (@(posedge mclk) // RULE17
		disable iff (!rst_n)
		$past(rst_n) |-> read_monitor == ($past(read_scan_sel) < 3'(TRACKS)
		? $past(read_bus[read_scan_sel]) : 1'b0))
		else $error("read monitor not routed from selected track");

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence run_end_s;
		mv_state_r == tester_pkg::MV_RUN && mv_count_r == RUN_CYC - 1;
	endsequence

	chk_stop_holds: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
		$past(motion_mode) == tester_pkg::MOTION_STOP |-> !tape_motion)
		else $error("motion active in stop setting");
	chk_run_holds: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
		$past(motion_mode) == tester_pkg::MOTION_RUN |-> tape_motion)
		else $error("motion inactive in run setting");
	chk_ss_follow: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
		$past(motion_mode) == tester_pkg::MOTION_START_STOP
		|-> tape_motion == $past(motion_sync))
		else $error("start-stop motion not following multivibrator");
	chk_stop_bound: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
		mv_state_r == tester_pkg::MV_STOP |-> mv_count_r < STOP_MAX_CYC)
		else $error("stop phase too long");
	chk_run_end: assert property (@(posedge mclk) disable iff (!rst_n) // RULE5
		run_end_s |=> mv_state_r == tester_pkg::MV_STOP && mv_count_r == 0)
		else $error("run phase length wrong");
	chk_no_gap: assert property (@(posedge mclk) disable iff (!rst_n) // RULE20
		$changed(mv_state_r) |-> mv_count_r == 0)
		else $error("phase change with stale count");
	chk_wp_gate: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
		!$past(write_enable) |-> !write_pulse)
		else $error("write pulse without write enable");
	chk_rate_hold: assert property (@(posedge mclk) disable iff (!rst_n) // RULE21
		!$past(osc_wrap) |-> $stable(osc_period_r))
		else $error("write rate changed mid-period");
	chk_rewind_ready: assert property (@(posedge mclk) disable iff (!rst_n) // RULE14
		drive_cmd.rewind_slow |-> $past(drive_ready) && $past(load_rewind_req))
		else $error("slow rewind without ready request");
	chk_unload_ready: assert property (@(posedge mclk) disable iff (!rst_n) // RULE15
		drive_cmd.rewind_unload |-> $past(drive_ready))
		else $error("unload without ready drive");
	chk_skew_route: assert property (@(posedge mclk) disable iff (!rst_n) // RULE16
		skew_sync == $past(read_bus[TRACKS]))
		else $error("skew sync not eighth track");

endmodule // tape_unit_offline_stimulus

// file: rtl/tester_defs.svh
// Timing and position constants for the off-line tape tester stimulus block.
// Assumes a 100 MHz mclk; all times are turned into cycle counts here.
//
// Functional notes
// RULE1 - Stop setting keeps motion command inactive
// RULE2 - Run setting holds motion command active
// RULE3 - Start-stop setting follows free multivibrator
// RULE4 - Stop phase adjustable 1 ms to 50 ms
// RULE5 - Run phase fixed near 20 ms
// RULE6 - Motion sync always carries multivibrator wave
// RULE7 - High density write oscillator 20 kHz
// RULE8 - Low density write oscillator 7.6 kHz
// RULE9 - Write pulses only with write enable on
// RULE10 - Seven track settings drive track data lines
// RULE11 - One enables toggle, zero blocks it
// RULE12 - Direction selector commands forward or backward
// RULE13 - Indicate selector gives on and off commands
// RULE14 - Load-rewind when ready starts slow rewind
// RULE15 - Rewind-unload when ready starts fast rewind
// RULE16 - Eighth track routed to sync output
// RULE17 - Track selector routes one read bus
// RULE18 - Read/write selector issues set-read or set-write
// RULE19 - End of tape never sensed or acted on
// RULE20 - Multivibrator phases alternate with no gap
// RULE21 - Density change applies at period boundary
`ifndef TESTER_DEFS_SVH
`define TESTER_DEFS_SVH

`define CLK_HZ 100000000
`define RUN_TIME_MS 20
`define STOP_MIN_MS 1
`define STOP_MAX_MS 50
`define HI_RATE_HZ 20000
`define LO_RATE_HZ 7600
`define RUN_CYC (`RUN_TIME_MS * (`CLK_HZ / 1000))
`define STOP_MIN_CYC (`STOP_MIN_MS * (`CLK_HZ / 1000))
`define STOP_MAX_CYC (`STOP_MAX_MS * (`CLK_HZ / 1000))
`define HI_PERIOD_CYC (`CLK_HZ / `HI_RATE_HZ)
`define LO_PERIOD_CYC (`CLK_HZ / `LO_RATE_HZ)
`define WPULSE_CYC 100
`define TRACK_COUNT 7
`define REG_STOP_TIME 4'h0
`define REG_STATUS 4'h4

`endif

// file: rtl/tester_pkg.sv
// Types for the off-line tape tester stimulus block.
// Assumes tester_defs.svh supplies the numbers.
package tester_pkg;

	typedef enum logic [1:0] {
		MOTION_STOP = 2'h0,
		MOTION_RUN = 2'h1,
		MOTION_START_STOP = 2'h2
	} motion_mode_e;

	typedef enum logic [1:0] {
		MV_RUN = 2'b01,
		MV_STOP = 2'b10
	} mv_state_e;

	typedef struct packed {
		logic set_read;
		logic set_write;
		logic dir_forward;
		logic dir_backward;
		logic tape_indicate_on;
		logic tape_indicate_off;
		logic rewind_slow;
		logic rewind_unload;
	} drive_cmd_s;

endpackage

// file: test/tape_drive_model.sv
// Behavioural tape drive that answers the tester during off-line checks.
// Assumes commands, pulses and track data are synchronous to mclk.
`timescale 1ns/1ps
module tape_drive_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic online,
	input wire logic tape_motion,
	input wire logic write_pulse,
	input wire logic [6:0] track_data,
	input wire tester_pkg::drive_cmd_s drive_cmd,
	output logic drive_ready,
	output logic [7:0] read_bus
);
	logic [6:0] write_ff_r;
	logic [4:0] rewind_cnt_r;
	logic pulse_d_r;
	logic tape_pos_r;
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			write_ff_r <= 7'h00;
			rewind_cnt_r <= 5'h00;
			pulse_d_r <= 1'b0;
			tape_pos_r <= 1'b0;
		end else begin
			pulse_d_r <= write_pulse;
			if (write_pulse && !pulse_d_r)
				write_ff_r <= write_ff_r ^ track_data;
			if (tape_motion)
				tape_pos_r <= ~tape_pos_r;
			if (rewind_cnt_r != 5'h00)
				rewind_cnt_r <= rewind_cnt_r - 5'h01;
			else if (drive_ready && (drive_cmd.rewind_slow ||
				drive_cmd.rewind_unload))
				rewind_cnt_r <= 5'h10;
		end
	end
	assign drive_ready = online && rewind_cnt_r == 5'h00;
	assign read_bus = {tape_pos_r, write_ff_r};
endmodule // tape_drive_model

// file: test/tape_unit_offline_stimulus_bench.sv
// Self-checking bench for the tape tester stimulus block.
// Assumes the drive model stands on the far side of the block.
`timescale 1ns/1ps
module tape_unit_offline_stimulus_bench;
	logic mclk = 1'b0, rst_n = 1'b0, online = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v;
	logic reg_write = 1'b0, reg_read = 1'b0;
	tester_pkg::motion_mode_e motion_mode = tester_pkg::MOTION_STOP;
	logic write_enable = 1'b0, write_rate_select = 1'b1;
	logic read_write_sel = 1'b0, direction_sel = 1'b0;
	logic tape_indicate_sel = 1'b0, drive_ready;
	logic load_rewind_req = 1'b0, rewind_unload_req = 1'b0;
	logic [6:0] track_setting = 7'h55, track_data;
	logic [7:0] read_bus;
	logic [2:0] read_scan_sel = 3'h0;
	logic tape_motion, motion_sync, write_pulse, skew_sync, read_monitor, ms_snap;
	tester_pkg::drive_cmd_s drive_cmd;
	int errors = 0, checks = 0, cycles = 0;
	////////////////////////////////////////////////////////////////////////
	tape_unit_offline_stimulus #(.RUN_CYC(20), .STOP_MIN_CYC(5),
		.HI_PERIOD_CYC(10), .LO_PERIOD_CYC(26),
		.WPULSE_CYC(2)) i_dut (.mclk, .rst_n, .reg_addr, .reg_wdata,
		.reg_write, .reg_read, .reg_rdata, .motion_mode, .write_enable,
		.write_rate_select, .read_write_sel, .direction_sel,
		.tape_indicate_sel, .load_rewind_req, .rewind_unload_req,
		.drive_ready, .track_setting, .read_bus, .read_scan_sel,
		.tape_motion, .motion_sync, .write_pulse, .track_data, .drive_cmd,
		.skew_sync, .read_monitor);
	tape_drive_model i_drive (.mclk, .rst_n, .online, .tape_motion,
		.write_pulse, .track_data, .drive_cmd, .drive_ready, .read_bus);
	always #5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		step(1);
		reg_write <= 1'b0;
		step(1);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_read <= 1'b1;
		step(1);
		reg_read <= 1'b0;
		d = reg_rdata;
		step(1);
	endtask
	task automatic wrap_up;
		if (errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Phase lengths of the multivibrator and how the motion line follows
	task automatic t_cycle(input tester_pkg::motion_mode_e m, input int st,
		input int ex);
		int hi, lo, w;
		logic prev, bad;
		wr(4'h0, st);
		motion_mode <= m;
		hi = 0;
		lo = 0;
		w = 0;
		bad = 1'b0;
		while (motion_sync !== 1'b0 && w < 200) begin step(1); w++; end
		while (motion_sync !== 1'b1 && w < 400) begin step(1); w++; end
		prev = 1'b1;
		while (motion_sync !== 1'b0 && hi < 200) begin
			prev = motion_sync;
			step(1);
			hi++;
			bad |= tape_motion !== (m == tester_pkg::MOTION_START_STOP ? prev : 1'b0);
		end
		while (motion_sync === 1'b0 && lo < 200) begin
			prev = motion_sync;
			step(1);
			lo++;
			bad |= tape_motion !== (m == tester_pkg::MOTION_START_STOP ? prev : 1'b0);
		end
		chk("run_phase", 20, hi);
		chk("stop_phase", ex, lo);
		chk("motion_follow", 0, bad);
	endtask
	// Write pulse period and width at one density
	task automatic t_wpulse(input logic s, input int per);
		int p, h;
		logic last;
		write_rate_select <= s;
		write_enable <= 1'b1;
		step(60);
		p = 0;
		while (write_pulse === 1'b1 && p < 60) begin step(1); p++; end
		while (write_pulse !== 1'b1 && p < 60) begin step(1); p++; end
		p = 0;
		h = 0;
		do begin
			if (write_pulse === 1'b1) h++;
			last = write_pulse;
			step(1);
			p++;
		end while (!(write_pulse === 1'b1 && last === 1'b0) && p < 100);
		chk("wp_period", per, p);
		chk("wp_width", 2, h);
	endtask
	task automatic t_wdis;
		int h;
		write_enable <= 1'b0;
		step(2);
		h = 0;
		for (int i = 0; i < 60; i++) begin
			write_rate_select <= i[3];
			step(1);
			if (write_pulse !== 1'b0) h++;
		end
		chk("wp_disabled", 0, h);
	endtask
	task automatic t_panel;
		logic [7:0] e;
		for (int i = 0; i < 8; i++) begin
			{read_write_sel, direction_sel, tape_indicate_sel} <= i[2:0];
			track_setting <= {i[2:0], ~i[3:0]};
			step(1);
			e = {~i[2], i[2], i[1], ~i[1], i[0], ~i[0], 2'b00};
			chk("drive_cmd", e, drive_cmd);
			chk("track_data", {i[2:0], ~i[3:0]}, track_data);
		end
		for (int j = 0; j < 4; j++) begin
			online <= j[0];
			load_rewind_req <= ~j[1];
			rewind_unload_req <= j[1];
			step(1);
			chk("rewind", {j[0] & ~j[1], j[0] & j[1]}, drive_cmd[1:0]);
			load_rewind_req <= 1'b0;
			rewind_unload_req <= 1'b0;
			step(40);
		end
		online <= 1'b1;
	endtask
	// Monitor routing while the tape runs continuously
	task automatic t_monitor;
		logic [7:0] prev;
		motion_mode <= tester_pkg::MOTION_RUN;
		write_rate_select <= 1'b1;
		write_enable <= 1'b1;
		for (int s = 0; s < 8; s++) begin
			read_scan_sel <= s[2:0];
			track_setting <= 7'h01 << s[2:0];
			step(2);
			chk("tape_motion", 1, tape_motion);
			for (int k = 0; k < 12; k++) begin
				prev = read_bus;
				step(1);
				chk("read_monitor", s == 7 ? 1'b0 : prev[s], read_monitor);
				chk("skew_sync", prev[7], skew_sync);
			end
		end
		write_enable <= 1'b0;
		step(1);
		ms_snap = motion_sync;
		rd(4'h4, rd_v);
		chk("status", {28'h0, 1'b0, ms_snap, 1'b1, ms_snap}, rd_v);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			wrap_up;
		end
	end
	initial begin
		step(8);
		chk("reset_sync", 1, motion_sync);
		chk("reset_out", 0, {tape_motion, write_pulse, drive_cmd});
		rst_n <= 1'b1;
		step(1);
		wr(4'h0, 32'h5);
		rd(4'h0, rd_v);
		chk("stop_time", 5, rd_v);
		rd(4'h8, rd_v);
		chk("unmapped", 0, rd_v);
		wr(4'h4, 32'hf);
		ms_snap = motion_sync;
		rd(4'h4, rd_v);
		chk("status", {28'h0, 1'b0, ms_snap, 1'b0, ms_snap}, rd_v);
		t_cycle(tester_pkg::MOTION_START_STOP, 5, 5);
		t_cycle(tester_pkg::MOTION_START_STOP, 50, 50);
		t_cycle(tester_pkg::MOTION_STOP, 3, 5);
		t_cycle(tester_pkg::motion_mode_e'(2'h3), 5, 5);
		t_wpulse(1'b1, 10);
		t_wpulse(1'b0, 26);
		t_wdis;
		t_panel;
		t_monitor;
		wrap_up;
	end
endmodule // tape_unit_offline_stimulus_bench
